// ==== tbo_defs.vh ====
// Shared constants for the touch button output control block.
// Included by the top-level design file only; definitions only.
`ifndef TBO_DEFS_VH
`define TBO_DEFS_VH

// Clock and timing (10 MHz reference clock)
`define TBO_CLK_HZ          10000000
`define TBO_TICK_MS         20
`define TBO_TICK_CYC        ((`TBO_CLK_HZ / 1000) * `TBO_TICK_MS)
`define TBO_PULSE_MS        5
`define TBO_PULSE_CYC       ((`TBO_CLK_HZ / 1000) * `TBO_PULSE_MS)
`define TBO_START_NORM_MS   350
`define TBO_START_HIGH_MS   1000
`define TBO_AUTO_SHORT_S    5
`define TBO_AUTO_LONG_S     20

// Threshold limits and defaults
`define TBO_THR_MIN         8'h32
`define TBO_THR_MAX         8'hf5
`define TBO_THR_RST         8'h64
`define TBO_HOLD_MAX        8'hff

// Wishbone register offsets (byte addresses)
`define TBO_REG_CTRL        8'h00
`define TBO_REG_TOGGLE      8'h04
`define TBO_REG_FLANK       8'h08
`define TBO_REG_THRESH      8'h0c
`define TBO_REG_HOLD        8'h10
`define TBO_REG_STATUS      8'h14
`define TBO_REG_DIAG        8'h18

// Control register bit positions
`define TBO_CTRL_NOISE_HI   0
`define TBO_CTRL_AUTO_THR   1
`define TBO_CTRL_AUTO_RST   2
`define TBO_CTRL_AUTO_LONG  3
`define TBO_CTRL_W          4

`endif

// ==== tbo_tick_gen.v ====
// Free-running tick generator: one-cycle pulse every PERIOD cycles.
// Assumes a single clock and a synchronous clock enable.
`timescale 1ns/1ps
module tbo_tick_gen #(
  parameter integer PERIOD = 200000,
  parameter integer CW     = 18
) (
  // Clock, reset, enable
  input  wire          ref_clk,
  input  wire          sys_rst,
  input  wire          clk_en,
  // Tick out
  output reg           tick_q
);

  reg  [CW-1:0] cnt_q;

  // Counter wraps at PERIOD-1 and pulses the tick
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q  <= {CW{1'b0}};
      tick_q <= 1'b0;
    end else if (clk_en) begin
      if (cnt_q == PERIOD[CW-1:0] - 1'b1) begin
        cnt_q  <= {CW{1'b0}};
        tick_q <= 1'b1;
      end else begin
        cnt_q  <= cnt_q + 1'b1;
        tick_q <= 1'b0;
      end
    end
  end

endmodule

// ==== tbo_btn_detect.v ====
// Finger threshold comparator for one button: count against threshold.
// Assumes counts arrive synchronous to ref_clk with a valid strobe.
`timescale 1ns/1ps
module tbo_btn_detect #(
  parameter integer CNT_W = 8
) (
  // Clock, reset, enable
  input  wire             ref_clk,
  input  wire             sys_rst,
  input  wire             clk_en,
  // Count and threshold
  input  wire             cnt_valid,
  input  wire [CNT_W-1:0] sig_cnt,
  input  wire [CNT_W-1:0] threshold,
  // Decision
  output reg              touch_q
);

  // Decision updates only on a fresh count, holds between scans
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      touch_q <= 1'b0;
    end else if (clk_en && cnt_valid) begin
      touch_q <= (sig_cnt >= threshold);
    end
  end

endmodule

// ==== tbo_top.v ====
// Touch button output control: ten sensed buttons to ten active-low outputs.
// Assumes per-button counts and diagnostic results come from the sensing
// front end synchronous to ref_clk; registers reached over classic Wishbone.
`timescale 1ns/1ps
`include "tbo_defs.vh"
module tbo_top #(
  parameter integer NBTN       = 10,
  parameter integer CNT_W      = 8,
  parameter integer START_NORM = (`TBO_CLK_HZ / 1000) * `TBO_START_NORM_MS,
  parameter integer START_HIGH = (`TBO_CLK_HZ / 1000) * `TBO_START_HIGH_MS,
  parameter integer PULSE_CYC  = `TBO_PULSE_CYC,
  parameter integer TICK_CYC   = `TBO_TICK_CYC,
  parameter integer AUTO_SHORT = `TBO_AUTO_SHORT_S * 1000 / `TBO_TICK_MS,
  parameter integer AUTO_LONG  = `TBO_AUTO_LONG_S * 1000 / `TBO_TICK_MS
) (
  // Clock, reset, enable
  input  wire                   ref_clk,
  input  wire                   sys_rst,
  input  wire                   clk_en,
  // Sensing front end
  input  wire [NBTN-1:0]        button_sense_input,
  input  wire [NBTN*CNT_W-1:0]  sig_cnt,
  input  wire [NBTN-1:0]        cnt_valid,
  input  wire [CNT_W-1:0]       auto_threshold,
  input  wire [NBTN-1:0]        diag_fail,
  // Outputs to LEDs
  output reg  [NBTN-1:0]        button_led_output,
  // Wishbone slave
  input  wire                   wb_cyc_i,
  input  wire                   wb_stb_i,
  input  wire                   wb_we_i,
  input  wire [7:0]             wb_adr_i,
  input  wire [3:0]             wb_sel_i,
  input  wire [31:0]            wb_dat_i,
  output reg  [31:0]            wb_dat_o,
  output reg                    wb_ack_o
);

  ////////////////////////////////////////////////////////////////////////
  // Start-up sequence states
  localparam [2:0] ST_WAIT  = 3'b001;
  localparam [2:0] ST_PULSE = 3'b010;
  localparam [2:0] ST_RUN   = 3'b100;

  reg  [2:0]              state_q;
  reg  [23:0]             seq_cnt_q;
  reg  [`TBO_CTRL_W-1:0]  ctrl_q;
  reg  [NBTN-1:0]         toggle_en_q;
  reg  [NBTN-1:0]         flank_suppress_q;
  reg  [CNT_W-1:0]        man_thr_q;
  reg  [7:0]              hold_ticks_q;
  reg  [NBTN-1:0]         diag_q;
  reg  [NBTN-1:0]         prev_on_q;
  reg  [NBTN-1:0]         tgl_q;
  reg  [NBTN-1:0]         stuck_q;
  reg  [NBTN-1:0]         owner_q;
  reg  [NBTN-1:0]         hold_sel_q;
  reg  [7:0]              hold_cnt_q;
  reg  [NBTN*10-1:0]      touch_time_q;
  wire [NBTN-1:0]         touch_raw;
  wire                    tick;
  wire [CNT_W-1:0]        thr_eff;
  wire                    running;
  reg  [NBTN-1:0]         free_on;
  reg  [NBTN-1:0]         on_d;
  reg  [NBTN-1:0]         rel_d;
  reg  [NBTN-1:0]         owner_d;
  reg  [NBTN-1:0]         led_d;
  reg  [NBTN-1:0]         tgl_d;
  reg  [NBTN-1:0]         hold_now;
  integer                 i;

  assign running = (state_q == ST_RUN);

  // Threshold source: automatic value or manual register
  assign thr_eff = ctrl_q[`TBO_CTRL_AUTO_THR] ? auto_threshold : man_thr_q;

  ////////////////////////////////////////////////////////////////////////
  // Clamp a manual threshold into the accepted window
  function [CNT_W-1:0] clamp_thr;
    input [CNT_W-1:0] v;
    begin
      if (v < `TBO_THR_MIN)
        clamp_thr = `TBO_THR_MIN;
      else if (v > `TBO_THR_MAX)
        clamp_thr = `TBO_THR_MAX;
      else
        clamp_thr = v;
    end
  endfunction

  // Lowest set bit of a vector, used for tie-breaks
  function [NBTN-1:0] first_bit;
    input [NBTN-1:0] v;
    integer k;
    begin
      first_bit = {NBTN{1'b0}};
      for (k = NBTN - 1; k >= 0; k = k - 1) begin
        if (v[k])
          first_bit = {{(NBTN-1){1'b0}}, 1'b1} << k;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // One comparator per button
  genvar g;
  generate
    for (g = 0; g < NBTN; g = g + 1) begin : g_det
      tbo_btn_detect #(
        .CNT_W     (CNT_W)
      ) u_det (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .cnt_valid (cnt_valid[g] & button_sense_input[g] & running),
        .sig_cnt   (sig_cnt[g*CNT_W +: CNT_W]),
        .threshold (thr_eff),
        .touch_q   (touch_raw[g])
      );
    end
  endgenerate

  // Shared 20 ms tick for hold and stuck timers
  tbo_tick_gen #(
    .PERIOD    (TICK_CYC),
    .CW        (24)
  ) u_tick (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .tick_q    (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Start-up: wait, optional diagnostic pulse, then run
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q   <= ST_WAIT;
      seq_cnt_q <= 24'h000000;
      diag_q    <= {NBTN{1'b0}};
    end else if (clk_en) begin
      case (state_q)
        ST_WAIT: begin
          seq_cnt_q <= seq_cnt_q + 24'h000001;
          if (seq_cnt_q == (ctrl_q[`TBO_CTRL_NOISE_HI] ? START_HIGH[23:0] - 24'h1
                                                         : START_NORM[23:0] - 24'h1)) begin
            seq_cnt_q <= 24'h000000;
            diag_q    <= diag_fail;
            state_q   <= (|diag_fail) ? ST_PULSE : ST_RUN;
          end
        end
        ST_PULSE: begin
          seq_cnt_q <= seq_cnt_q + 24'h000001;
          if (seq_cnt_q == PULSE_CYC[23:0] - 24'h1) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Suppression and release decisions; toggle and hold are resolved here
  // too, so the output register sees them in the cycle of the touch
  always @* begin
    free_on = touch_raw & ~stuck_q & ~flank_suppress_q;
    // Keep the earlier owner while it is still touched, else pick a new one
    if (|(owner_q & touch_raw & ~stuck_q))
      owner_d = owner_q;
    else
      owner_d = first_bit(touch_raw & ~stuck_q & flank_suppress_q);
    on_d  = free_on | owner_d;
    rel_d = prev_on_q & ~on_d & ~stuck_q & ~toggle_en_q;
    // Next toggle level, shown at once so toggle and direct buttons
    // answer a touch with the same latency
    tgl_d = tgl_q ^ (on_d & ~prev_on_q & toggle_en_q);
    // A fresh release takes the hold in its own cycle; waiting for the
    // register would let the pin blink high for one cycle
    if (|rel_d)
      hold_now = (hold_ticks_q != 8'h00) ? first_bit(rel_d) : {NBTN{1'b0}};
    else
      hold_now = hold_sel_q;
  end

  // Stuck timers: per-button touch duration in 20 ms ticks
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      touch_time_q <= {NBTN*10{1'b0}};
      stuck_q      <= {NBTN{1'b0}};
    end else if (clk_en) begin
      for (i = 0; i < NBTN; i = i + 1) begin
        if (!touch_raw[i] || !ctrl_q[`TBO_CTRL_AUTO_RST]) begin
          touch_time_q[i*10 +: 10] <= 10'h000;
          stuck_q[i]               <= 1'b0;
        end else if (tick && !stuck_q[i]) begin
          touch_time_q[i*10 +: 10] <= touch_time_q[i*10 +: 10] + 10'h001;
          if (touch_time_q[i*10 +: 10] ==
              (ctrl_q[`TBO_CTRL_AUTO_LONG] ? AUTO_LONG[9:0] : AUTO_SHORT[9:0]) - 10'h1)
            stuck_q[i] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Button state, toggle latch and hold timer
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_on_q  <= {NBTN{1'b0}};
      tgl_q      <= {NBTN{1'b0}};
      owner_q    <= {NBTN{1'b0}};
      hold_sel_q <= {NBTN{1'b0}};
      hold_cnt_q <= 8'h00;
    end else if (clk_en) begin
      if (!running) begin
        prev_on_q  <= {NBTN{1'b0}};
        tgl_q      <= {NBTN{1'b0}};
        owner_q    <= {NBTN{1'b0}};
        hold_sel_q <= {NBTN{1'b0}};
        hold_cnt_q <= 8'h00;
      end else begin
        prev_on_q <= on_d;
        owner_q   <= owner_d;
        tgl_q     <= tgl_d;
        if (|rel_d && hold_ticks_q != 8'h00) begin
          hold_sel_q <= first_bit(rel_d);
          hold_cnt_q <= hold_ticks_q;
        end else if (|rel_d) begin
          hold_sel_q <= {NBTN{1'b0}};
          hold_cnt_q <= 8'h00;
        end else if (tick && hold_cnt_q != 8'h00) begin
          hold_cnt_q <= hold_cnt_q - 8'h01;
          if (hold_cnt_q == 8'h01)
            hold_sel_q <= {NBTN{1'b0}};
        end
        // A hold ends once its button is touched again
        if (|(hold_sel_q & on_d) && !(|rel_d))
          hold_sel_q <= hold_sel_q & ~on_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output level, active low; toggle buttons show the latch
  // Holds never reach toggle buttons, their latch already keeps the level
  always @* begin
    led_d = {NBTN{1'b1}};
    if (state_q == ST_PULSE)
      led_d = ~diag_q;
    else if (running)
      led_d = ~((on_d & ~toggle_en_q) | (tgl_d & toggle_en_q)
                | (hold_now & ~toggle_en_q));
  end

  // Registered outputs so pins never glitch
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      button_led_output <= {NBTN{1'b1}};
    else if (clk_en)
      button_led_output <= led_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request, for one cycle.
  // Read data is loaded with the ack; a write lands only at the edge where
  // the master samples ack high, so it lands once and with settled data.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o         <= 1'b0;
      wb_dat_o         <= 32'h00000000;
      ctrl_q           <= {`TBO_CTRL_W{1'b0}};
      toggle_en_q      <= {NBTN{1'b0}};
      flank_suppress_q <= {NBTN{1'b0}};
      man_thr_q        <= `TBO_THR_RST;
      hold_ticks_q     <= 8'h00;
    end else if (clk_en) begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      // Read side: capture on the request edge; unmapped offsets read zero
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= 32'h00000000;
        if (wb_adr_i == `TBO_REG_CTRL)
          wb_dat_o[`TBO_CTRL_W-1:0] <= ctrl_q;
        else if (wb_adr_i == `TBO_REG_TOGGLE)
          wb_dat_o[NBTN-1:0] <= toggle_en_q;
        else if (wb_adr_i == `TBO_REG_FLANK)
          wb_dat_o[NBTN-1:0] <= flank_suppress_q;
        else if (wb_adr_i == `TBO_REG_THRESH)
          wb_dat_o[CNT_W-1:0] <= man_thr_q;
        else if (wb_adr_i == `TBO_REG_HOLD)
          wb_dat_o[7:0] <= hold_ticks_q;
        else if (wb_adr_i == `TBO_REG_STATUS) begin
          wb_dat_o[NBTN-1:0]     <= prev_on_q;
          wb_dat_o[16+NBTN-1:16] <= stuck_q;
          wb_dat_o[31:29]        <= state_q;
        end else if (wb_adr_i == `TBO_REG_DIAG)
          wb_dat_o[NBTN-1:0] <= diag_q;
      end
      // Write side: while the ack stands; 10-bit registers need two lanes
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i) begin
        if (wb_adr_i == `TBO_REG_CTRL && wb_sel_i[0])
          ctrl_q <= wb_dat_i[`TBO_CTRL_W-1:0];
        else if (wb_adr_i == `TBO_REG_TOGGLE && wb_sel_i[0] && wb_sel_i[1])
          toggle_en_q <= wb_dat_i[NBTN-1:0];
        else if (wb_adr_i == `TBO_REG_FLANK && wb_sel_i[0] && wb_sel_i[1])
          flank_suppress_q <= wb_dat_i[NBTN-1:0];
        else if (wb_adr_i == `TBO_REG_THRESH && wb_sel_i[0])
          man_thr_q <= clamp_thr(wb_dat_i[CNT_W-1:0]);
        else if (wb_adr_i == `TBO_REG_HOLD && wb_sel_i[0])
          hold_ticks_q <= wb_dat_i[7:0];
      end
    end
  end

endmodule

// ==== tbo_led_load.sv ====
// LED loads hanging on the active-low button outputs.
// Assumes each LED sinks into its output pin, so low means lit.
`timescale 1ns/1ps
module tbo_led_load #(
  parameter integer NBTN = 10
) (
  // Drive from the block
  input  wire logic [NBTN-1:0] button_led_output,
  // Seen brightness
  output logic      [NBTN-1:0] led_lit
);
  // LED conducts only while its pin sinks current
  assign led_lit = ~button_led_output;
endmodule

// ==== tbo_top_checker.sv ====
// Checker for tbo_top: bus answer timing, start-up dark time, output causes.
// Sees only the top ports; bound into every tbo_top below.
`timescale 1ns/1ps
module tbo_top_checker #(
  parameter integer NBTN       = 10,
  parameter integer START_NORM = 50,
  parameter integer START_HIGH = 100
) (
  // Clock and reset
  input wire logic            ref_clk,
  input wire logic            sys_rst,
  input wire logic            clk_en,
  // Buttons and outputs
  input wire logic [NBTN-1:0] button_sense_input,
  input wire logic [NBTN-1:0] cnt_valid,
  input wire logic [NBTN-1:0] button_led_output,
  // Wishbone
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_we_i,
  input wire logic [7:0]      wb_adr_i,
  input wire logic [31:0]     wb_dat_o,
  input wire logic            wb_ack_o
);
  ////////////////////////////////////////
  logic [31:0]     age_q;
  logic [NBTN-1:0] led_q;
  wire             any_vld = |cnt_valid;
  // Past both start-up waits and the pulse, only touches move outputs
  wire             run = age_q > START_HIGH + 8;
  // Saturating age since reset, previous outputs
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      age_q <= 32'h0;
      led_q <= {NBTN{1'b1}};
    end else begin
      if (age_q != 32'hffffffff) begin
        age_q <= age_q + 32'h1;
      end
      led_q <= button_led_output;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  // First lighting of any output during start-up is the fail pulse
  sequence s_dark;
    &led_q && !(&button_led_output) && !run;
  endsequence
  a_ack_latency: assert property (s_req |=> s_ack)
    else $error("ack not one cycle after request");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h1c |-> wb_dat_o == 0)
    else $error("unmapped read not zero");
  a_data_holds: assert property (!(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data moved outside access");
  a_start_dark: assert property (age_q < START_NORM |-> &button_led_output)
    else $error("output on during start-up");
  // Bench runs with a pulse of 5 cycles
  a_pulse_width: assert property (s_dark |-> (!(&button_led_output))[*5] ##1 &button_led_output)
    else $error("fail pulse width wrong");
  a_fall_cause: assert property (run && |(led_q & ~button_led_output) |-> $past(any_vld, 2))
    else $error("output on without a count");
  a_unused_dark: assert property (run |-> &(button_led_output | button_sense_input))
    else $error("unconnected button output on");
endmodule

bind tbo_top tbo_top_checker #(.NBTN(NBTN), .START_NORM(START_NORM), .START_HIGH(START_HIGH))
  u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .button_sense_input(button_sense_input), .cnt_valid(cnt_valid),
  .button_led_output(button_led_output), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// ==== tbo_top_tb.sv ====
// Testbench: scenario tasks on tbo_top with shortened counts.
// Assumes LED loads on the outputs and button 9 left unconnected.
`timescale 1ns/1ps
module tbo_top_tb;
  localparam integer SN = 50;
  localparam integer SH = 100;
  localparam integer PC = 5;
  localparam integer TK = 10;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_en = 1'b1;
  logic [9:0]  cnt_valid = 10'h0;
  logic [79:0] sig_cnt = 80'h0;
  logic [7:0]  auto_thr = 8'h80;
  logic [9:0]  diag_fail = 10'h008;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [9:0]  leds;
  logic [9:0]  lit;
  logic [31:0] rd;
  int          waited;
  int          miscompares = 0;
  int          n_compared = 0;
  ////////////////////////////////////////
  // Clock at 100 ns
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  // Block and its loads
  tbo_top #(.START_NORM(SN), .START_HIGH(SH), .PULSE_CYC(PC), .TICK_CYC(TK),
    .AUTO_SHORT(3), .AUTO_LONG(6)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .button_sense_input(10'h1ff), .sig_cnt(sig_cnt),
    .cnt_valid(cnt_valid), .auto_threshold(auto_thr), .diag_fail(diag_fail),
    .button_led_output(leds), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  tbo_led_load #(.NBTN(10)) u_load (.button_led_output(leds), .led_lit(lit));
  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Classic single cycle; the bound only guards against a hang
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    check(wb_ack_o, 1'b1);
    if (wb_ack_o !== 1'b1) tally_and_finish;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // One fresh count for button i, then two edges for the output
  task automatic cnt(input int i, input logic [7:0] v);
    @(posedge ref_clk);
    sig_cnt[8*i +: 8] <= v;
    cnt_valid[i] <= 1'b1;
    @(posedge ref_clk);
    cnt_valid[i] <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic wait_out(input logic [9:0] e, input int lim);
    waited = 0;
    while (leds !== e && waited < lim) begin
      @(posedge ref_clk);
      waited++;
    end
    check(leds, e);
    if (leds !== e) tally_and_finish;
  endtask
  ////////////////////////////////////////
  task automatic sc_diag(input int st, input logic [9:0] f);
    wait_out(~f, st + 8);
    check(waited >= st - 6 && waited <= st + 4, 1'b1);
    wait_out(10'h3ff, PC + 2);
    check(waited, PC);
  endtask
  task automatic sc_regs;
    xfer(0, 8'h0c, 0);
    check(rd, 32'h64);
    xfer(1, 8'h0c, 32'h10);
    xfer(0, 8'h0c, 0);
    check(rd, 32'h32);
    xfer(1, 8'h0c, 32'hff);
    xfer(0, 8'h0c, 0);
    check(rd, 32'hf5);
    xfer(1, 8'h1c, 32'h5a);
    xfer(0, 8'h1c, 0);
    check(rd, 32'h0);
    xfer(1, 8'h0c, 32'h40);
    xfer(1, 8'h10, 32'h0);
  endtask
  task automatic sc_touch;
    for (int i = 0; i < 9; i++) begin
      cnt(i, 8'h40);
      check(lit, 10'h1 << i);
      cnt(i, 8'h3f);
      repeat (TK) @(posedge ref_clk);
      check(lit, 10'h0);
    end
  endtask
  task automatic sc_hold;
    xfer(1, 8'h10, 32'h3);
    cnt(1, 8'h50);
    cnt(1, 8'h10);
    repeat (17) @(posedge ref_clk);
    check(lit, 10'h002);
    wait_out(10'h3ff, 16);
    cnt(1, 8'h50);
    cnt(2, 8'h50);
    cnt(1, 8'h10);
    check(lit, 10'h006);
    cnt(2, 8'h10);
    check(lit, 10'h004);
    wait_out(10'h3ff, 40);
  endtask
  task automatic sc_toggle;
    xfer(1, 8'h04, 32'h10);
    cnt(4, 8'h50);
    cnt(4, 8'h10);
    repeat (40) @(posedge ref_clk);
    check(lit, 10'h010);
    cnt(3, 8'h50);
    check(lit, 10'h018);
    cnt(4, 8'h50);
    cnt(4, 8'h10);
    check(lit, 10'h008);
    cnt(3, 8'h10);
    wait_out(10'h3ff, 40);
    xfer(1, 8'h04, 32'h0);
  endtask
  task automatic sc_flank;
    xfer(1, 8'h10, 32'h0);
    xfer(1, 8'h08, 32'h60);
    cnt(5, 8'h50);
    cnt(6, 8'h50);
    check(lit, 10'h020);
    cnt(7, 8'h50);
    check(lit, 10'h0a0);
    cnt(5, 8'h10);
    check(lit, 10'h0c0);
    cnt(6, 8'h10);
    cnt(7, 8'h10);
    wait_out(10'h3ff, TK + 2);
  endtask
  task automatic sc_auto;
    xfer(1, 8'h00, 32'h2);
    cnt(2, 8'h7f);
    check(lit, 10'h0);
    cnt(2, 8'h80);
    check(lit, 10'h004);
    cnt(2, 8'h10);
    wait_out(10'h3ff, TK + 2);
  endtask
  // Stuck reset for both periods; the 5-tick hold set first must not follow a stuck release
  task automatic sc_stuck;
    xfer(1, 8'h10, 32'h5);
    for (int k = 3; k <= 6; k += 3) begin
      xfer(1, 8'h00, (k == 6) ? 32'hc : 32'h4);
      cnt(8, 8'h50);
      check(lit, 10'h100);
      wait_out(10'h3ff, k * TK + TK + 4);
      check(waited >= (k - 1) * TK - 4, 1'b1);
      // Release first: clearing the enable under a held touch relights it
      cnt(8, 8'h10);
      xfer(1, 8'h00, 32'h0);
      repeat (TK) @(posedge ref_clk);
    end
  endtask
  // Enable low freezes a running hold well past its natural end
  task automatic sc_freeze;
    xfer(1, 8'h10, 32'h3);
    cnt(0, 8'h50);
    cnt(0, 8'h10);
    clk_en <= 1'b0;
    repeat (4 * TK) @(posedge ref_clk);
    check(lit, 10'h001);
    clk_en <= 1'b1;
    wait_out(10'h3ff, 4 * TK);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    sc_diag(SN, 10'h008);
    repeat (SH) @(posedge ref_clk);
    sc_regs;
    sc_touch;
    sc_hold;
    sc_toggle;
    sc_flank;
    sc_auto;
    sc_stuck;
    sc_freeze;
    sys_rst <= 1'b1;
    diag_fail <= 10'h021;
    repeat (3) @(posedge ref_clk);
    check(leds, 10'h3ff);
    sys_rst <= 1'b0;
    xfer(1, 8'h00, 32'h1);
    sc_diag(SH - 4, 10'h021);
    tally_and_finish;
  end
endmodule
